/* File: src/fsr_pkg.sv */
// Purpose: Shared constants for the flow sensor two-wire read link
// Assumes: 100 MHz core clock on both ends
// Notes: Master derives the serial clock from its core clock
package fsr_pkg;
	localparam logic [6:0] FSR_ADDR = 7'h50;
	localparam logic FSR_RD_BIT = 1'b1;
	localparam int FSR_BYTES = 5;
	localparam int FSR_CORE_HZ = 100000000;
	localparam int FSR_RATE_100K = 100000;
	localparam int FSR_RATE_400K = 400000;
	// Quarter serial period counts, least value rounded up
	localparam int FSR_Q100 = (FSR_CORE_HZ + 4 * FSR_RATE_100K - 1) / (4 * FSR_RATE_100K);
	localparam int FSR_Q400 = (FSR_CORE_HZ + 4 * FSR_RATE_400K - 1) / (4 * FSR_RATE_400K);
	localparam logic [11:0] FSR_FLOW_RST = 12'h000;
	localparam logic [3:0] FSR_CNT_RST = 4'h0;
endpackage

/* File: src/fsr_link_if.sv */
// Purpose: Open-drain serial link between sensor end and master end
// Assumes: Pull-ups modelled as wired-and of released lines
// Notes: Enables are high while a party pulls its line low
`timescale 1ns/100ps
interface fsr_link_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_s;
	logic scl;
	logic sda;
	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_s);
	modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
	modport sensor (output sda_oe_s, input scl, input sda);
endinterface

/* File: src/fsr_sensor.sv */
// Purpose: Sensor end: slave that returns checksum and flow bytes on a read
// Assumes: Serial lines sampled by core clock through two flip-flops
// Notes: Sample is frozen at the address byte so one read stays coherent
//
// Behaviour
// - Master opens with start condition
// - Master closes with stop condition
// - Eight bits then one response bit
// - After acknowledge master continues or stops
// - Sensor acknowledges received byte, then releases
// - Undriven response means not-acknowledge
// - Sample on rising clock, hold while high
// - Measure continuously, no trigger needed
// - Send most significant bit first, expect acknowledge
// - Read is start, address, read bit
// - Checksum first, then data high first
// - Flow is twelve bits, upper bits zero
// - Checksum is negated byte sum
// - Master checks sum plus checksum is zero
// - Five bytes: checksum plus four data
// - Answer only address hex 50
// - Works at 100 and 400 kHz
`timescale 1ns/100ps
module fsr_sensor (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_flow,
	input wire logic i_flow_valid,
	output logic o_busy,
	fsr_link_if.sensor link
);
	typedef enum logic [2:0] {
		FSR_S_IDLE = 3'b000,
		FSR_S_ADDR = 3'b001,
		FSR_S_AACK = 3'b011,
		FSR_S_SEND = 3'b010,
		FSR_S_MACK = 3'b110
	} fsr_sstate_type;

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_d;
	logic sda_d;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], link.scl};
			sda_sync <= {sda_sync[0], link.sda};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end
	wire logic scl_rise = scl_sync[1] & ~scl_d;
	wire logic scl_fall = ~scl_sync[1] & scl_d;
	wire logic start_c = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	wire logic stop_c = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	// ------------------------------------------------------------
	// Continuous measurement and transfer state
	// ------------------------------------------------------------
	fsr_sstate_type state;
	fsr_sstate_type next_state;
	logic [11:0] flow;
	logic [11:0] next_flow;
	logic [11:0] snap;
	logic [11:0] next_snap;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [2:0] bytecnt;
	logic [2:0] next_bytecnt;
	logic sda_oe;
	logic next_sda_oe;
	logic [7:0] d_hi;
	logic [7:0] d_lo;
	logic [7:0] csum;
	logic [7:0] load;

	always_comb begin
		d_hi = {4'h0, snap[11:8]};
		d_lo = snap[7:0];
		csum = 8'h00 - (d_hi + d_lo + d_hi + d_lo);
		case (bytecnt)
			3'd0: load = d_hi;
			3'd1: load = d_lo;
			3'd2: load = d_hi;
			default: load = d_lo;
		endcase
	end

	always_comb begin
		next_state = state;
		next_flow = i_flow_valid ? i_flow : flow;
		next_snap = snap;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_bytecnt = bytecnt;
		next_sda_oe = sda_oe;
		if (stop_c) begin
			next_state = FSR_S_IDLE;
			next_sda_oe = 1'b0;
		end else if (start_c) begin
			next_state = FSR_S_ADDR;
			next_bitcnt = fsr_pkg::FSR_CNT_RST;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				FSR_S_ADDR: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_sync[1]};
						next_bitcnt = bitcnt + 4'd1;
					end else if (scl_fall && bitcnt == 4'd8) begin
						if (shreg == {fsr_pkg::FSR_ADDR, fsr_pkg::FSR_RD_BIT}) begin
							next_sda_oe = 1'b1;
							next_state = FSR_S_AACK;
							next_snap = flow;
						end else begin
							next_state = FSR_S_IDLE;
						end
					end
				end
				FSR_S_AACK: begin
					if (scl_fall) begin
						next_shreg = csum;
						next_bytecnt = 3'd0;
						next_bitcnt = 4'd1;
						next_sda_oe = ~csum[7];
						next_state = FSR_S_SEND;
					end
				end
				FSR_S_SEND: begin
					if (scl_fall) begin
						if (bitcnt == 4'd8) begin
							next_sda_oe = 1'b0;
							next_state = FSR_S_MACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_sda_oe = ~shreg[6];
							next_bitcnt = bitcnt + 4'd1;
						end
					end
				end
				FSR_S_MACK: begin
					if (scl_rise) begin
						if (sda_sync[1] || bytecnt == 3'(fsr_pkg::FSR_BYTES - 1)) begin
							next_state = FSR_S_IDLE;
						end else begin
							next_shreg = load;
						end
					end else if (scl_fall) begin
						next_bitcnt = 4'd1;
						next_sda_oe = ~shreg[7];
						next_bytecnt = bytecnt + 3'd1;
						next_state = FSR_S_SEND;
					end
				end
				default: next_state = FSR_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= FSR_S_IDLE;
			flow <= fsr_pkg::FSR_FLOW_RST;
			snap <= fsr_pkg::FSR_FLOW_RST;
			shreg <= 8'h00;
			bitcnt <= fsr_pkg::FSR_CNT_RST;
			bytecnt <= 3'd0;
			sda_oe <= 1'b0;
		end else begin
			state <= next_state;
			flow <= next_flow;
			snap <= next_snap;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			bytecnt <= next_bytecnt;
			sda_oe <= next_sda_oe;
		end
	end
	assign link.sda_oe_s = sda_oe;
	assign o_busy = (state != FSR_S_IDLE);
endmodule

/* File: src/fsr_master.sv */
// Purpose: Master end: reads five bytes and checks the checksum
// Assumes: Serial clock made here by a divider from the core clock
// Notes: i_fast selects 400 kHz, else 100 kHz
`timescale 1ns/100ps
module fsr_master (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_fast,
	output logic o_busy,
	output logic o_done,
	output logic o_nack,
	output logic o_ok,
	output logic [11:0] o_flow,
	fsr_link_if.master link
);
	typedef enum logic [2:0] {
		FSR_M_IDLE = 3'b000,
		FSR_M_START = 3'b001,
		FSR_M_ADDR = 3'b011,
		FSR_M_READ = 3'b010,
		FSR_M_STOP = 3'b110
	} fsr_mstate_type;

	// ------------------------------------------------------------
	// Quarter-period enable divider
	// ------------------------------------------------------------
	logic [7:0] div;
	logic [7:0] next_div;
	logic tick;
	always_comb begin
		tick = (div == 8'd0);
		next_div = tick ? (i_fast ? 8'(fsr_pkg::FSR_Q400 - 1) : 8'(fsr_pkg::FSR_Q100 - 1))
			: div - 8'd1;
	end

	logic sda_s1;
	logic sda_s2;
	fsr_mstate_type state;
	fsr_mstate_type next_state;
	logic [1:0] ph;
	logic [1:0] next_ph;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [2:0] bytecnt;
	logic [2:0] next_bytecnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] sum;
	logic [7:0] next_sum;
	logic [11:0] flow;
	logic [11:0] next_flow;
	logic scl_oe;
	logic next_scl_oe;
	logic sda_oe;
	logic next_sda_oe;
	logic done;
	logic next_done;
	logic nack;
	logic next_nack;
	logic ok;
	logic next_ok;

	// ------------------------------------------------------------
	// Bit engine: four phases per bit, clock low in 0 and 1
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_ph = ph;
		next_bitcnt = bitcnt;
		next_bytecnt = bytecnt;
		next_shreg = shreg;
		next_sum = sum;
		next_flow = flow;
		next_scl_oe = scl_oe;
		next_sda_oe = sda_oe;
		next_done = 1'b0;
		next_nack = nack;
		next_ok = ok;
		case (state)
			FSR_M_IDLE: begin
				next_scl_oe = 1'b0;
				next_sda_oe = 1'b0;
				if (i_go) begin
					next_state = FSR_M_START;
					next_ph = 2'd0;
					next_nack = 1'b0;
					next_ok = 1'b0;
					next_sum = 8'h00;
				end
			end
			FSR_M_START: if (tick) begin
				next_sda_oe = 1'b1;
				next_ph = ph + 2'd1;
				if (ph == 2'd1) begin
					next_scl_oe = 1'b1;
					next_shreg = {fsr_pkg::FSR_ADDR, fsr_pkg::FSR_RD_BIT};
					next_bitcnt = 4'd0;
					next_ph = 2'd0;
					next_state = FSR_M_ADDR;
				end
			end
			FSR_M_ADDR, FSR_M_READ: if (tick) begin
				next_ph = ph + 2'd1;
				case (ph)
					2'd0: begin
						if (state == FSR_M_ADDR)
							next_sda_oe = (bitcnt < 4'd8) ? ~shreg[7] : 1'b0;
						else if (bitcnt < 4'd8)
							next_sda_oe = 1'b0;
						else
							next_sda_oe = (bytecnt != 3'(fsr_pkg::FSR_BYTES - 1));
					end
					2'd1: next_scl_oe = 1'b0;
					2'd2: begin
						if (bitcnt < 4'd8) begin
							next_shreg = (state == FSR_M_ADDR) ? {shreg[6:0], 1'b0}
								: {shreg[6:0], sda_s2};
						end else if (state == FSR_M_ADDR && sda_s2) begin
							next_nack = 1'b1;
						end
					end
					default: begin
						next_scl_oe = 1'b1;
						next_bitcnt = bitcnt + 4'd1;
						if (bitcnt == 4'd8) begin
							next_bitcnt = 4'd0;
							if (state == FSR_M_ADDR) begin
								next_bytecnt = 3'd0;
								next_state = nack ? FSR_M_STOP : FSR_M_READ;
							end else begin
								next_sum = sum + shreg;
								if (bytecnt == 3'd1)
									next_flow[11:8] = shreg[3:0];
								if (bytecnt == 3'd2)
									next_flow[7:0] = shreg;
								next_bytecnt = bytecnt + 3'd1;
								if (bytecnt == 3'(fsr_pkg::FSR_BYTES - 1))
									next_state = FSR_M_STOP;
							end
						end
					end
				endcase
			end
			FSR_M_STOP: if (tick) begin
				next_ph = ph + 2'd1;
				case (ph)
					2'd0: next_sda_oe = 1'b1;
					2'd1: next_scl_oe = 1'b0;
					2'd2: next_sda_oe = 1'b0;
					default: begin
						next_done = 1'b1;
						next_ok = ~nack && (sum == 8'h00);
						next_state = FSR_M_IDLE;
					end
				endcase
			end
			default: next_state = FSR_M_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			div <= 8'd0;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			state <= FSR_M_IDLE;
			ph <= 2'd0;
			bitcnt <= 4'd0;
			bytecnt <= 3'd0;
			shreg <= 8'h00;
			sum <= 8'h00;
			flow <= fsr_pkg::FSR_FLOW_RST;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			ok <= 1'b0;
		end else begin
			div <= next_div;
			sda_s1 <= link.sda;
			sda_s2 <= sda_s1;
			state <= next_state;
			ph <= next_ph;
			bitcnt <= next_bitcnt;
			bytecnt <= next_bytecnt;
			shreg <= next_shreg;
			sum <= next_sum;
			flow <= next_flow;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			done <= next_done;
			nack <= next_nack;
			ok <= next_ok;
		end
	end
	assign link.scl_oe_m = scl_oe;
	assign link.sda_oe_m = sda_oe;
	assign o_busy = (state != FSR_M_IDLE);
	assign o_done = done;
	assign o_nack = nack;
	assign o_ok = ok;
	assign o_flow = flow;
endmodule

/* File: dv/fsr_link_checker.sv */
// Purpose: Assertions on the serial link
// Assumes: One core clock domain
// Notes: Counts clock rises per byte
`timescale 1ns/100ps
module fsr_link_checker (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic scl_oe_m,
	input wire logic sda_oe_m,
	input wire logic sda_oe_s,
	input wire logic scl,
	input wire logic sda
);
	// ----
	// Frame tracking
	// ----
	logic scl_q;
	logic sda_q;
	logic in_frame;
	logic [3:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic rise;
	logic start;
	logic stop;
	assign rise = scl & ~scl_q & in_frame;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop = scl & scl_q & ~sda_q & sda;
	always_ff @(posedge i_core_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (i_rst | stop) begin
			in_frame <= 1'b0;
		end else if (start) begin
			in_frame <= 1'b1;
			bit_cnt <= 4'h0;
			byte_cnt <= 3'h0;
		end else if (rise) begin
			bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
			byte_cnt <= (bit_cnt == 4'h8) ? byte_cnt + 3'h1 : byte_cnt;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	property p_hold;
		scl && scl_q |-> $stable(sda_oe_s);
	endproperty
	a_hold: assert property (p_hold) else $error("sensor data moved while clock high");
	property p_start;
		start |-> sda_oe_m && !sda_oe_s;
	endproperty
	a_start: assert property (p_start) else $error("start not made by master");
	property p_stop;
		stop && in_frame |-> bit_cnt == 4'h1 && byte_cnt == 3'h6;
	endproperty
	a_stop: assert property (p_stop) else $error("frame not six whole units");
	property p_addr;
		rise && byte_cnt == 3'h0 && bit_cnt < 4'h8 |-> !sda_oe_s;
	endproperty
	a_addr: assert property (p_addr) else $error("sensor drove during address");
	property p_ack;
		rise && byte_cnt == 3'h0 && bit_cnt == 4'h8 |-> sda_oe_s;
	endproperty
	a_ack: assert property (p_ack) else $error("address not acknowledged");
	property p_mute;
		rise && byte_cnt != 3'h0 && byte_cnt != 3'h6 && bit_cnt < 4'h8 |-> !sda_oe_m;
	endproperty
	a_mute: assert property (p_mute) else $error("master drove sensor data");
	property p_free;
		rise && byte_cnt != 3'h0 && bit_cnt == 4'h8 |-> !sda_oe_s;
	endproperty
	a_free: assert property (p_free) else $error("sensor held response bit");
	property p_last;
		rise && byte_cnt == 3'h5 && bit_cnt == 4'h8 |-> sda;
	endproperty
	a_last: assert property (p_last) else $error("last unit acknowledged");
	property p_idle;
		!in_frame |-> !scl_oe_m && !sda_oe_s;
	endproperty
	a_idle: assert property (p_idle) else $error("line pulled outside frame");
	property p_high;
		rise && byte_cnt != 3'h6 |-> scl [*8] ##[1:600] !scl;
	endproperty
	a_high: assert property (p_high) else $error("clock high time out of range");
endmodule

/* File: dv/flow_sensor_i2c_readout_test.sv */
// Purpose: Bench for both link ends
// Assumes: Second link driven by hand
// Notes: Wire bits captured on clock rises
`timescale 1ns/100ps
module flow_sensor_i2c_readout_test;
	typedef struct packed {
		logic [11:0] f;
		logic fs;
		logic okx;
	} fsr_row_type;
	localparam int Q = 3;
	fsr_row_type rows [3] = '{'{12'h199, 1'b0, 1'b1}, '{12'hfff, 1'b1, 1'b1}, '{12'h000, 1'b1, 1'b1}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] flow = 12'h000;
	logic go = 1'b0;
	logic fast = 1'b0;
	logic m_busy, s_busy, s_busy_b, done, nack, ok;
	logic [11:0] got_flow;
	logic [63:0] cap = 64'h0;
	logic [54:0] fr;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	fsr_link_if link_a();
	fsr_link_if link_b();
	fsr_link_if link_c();
	logic go_c = 1'b0;
	logic c_busy, c_nack, c_ok;
	logic [11:0] c_flow;
	fsr_sensor i_fsr_sensor(.i_core_clk(clk), .i_rst(rst), .i_flow(flow), .i_flow_valid(1'b1),
		.o_busy(s_busy), .link(link_a.sensor));
	fsr_sensor i_fsr_sensor_b(.i_core_clk(clk), .i_rst(rst), .i_flow(flow), .i_flow_valid(1'b1),
		.o_busy(s_busy_b), .link(link_b.sensor));
	fsr_master i_fsr_master(.i_core_clk(clk), .i_rst(rst), .i_go(go), .i_fast(fast),
		.o_busy(m_busy), .o_done(done), .o_nack(nack), .o_ok(ok), .o_flow(got_flow),
		.link(link_a.master));
	// No sensor answers on this link, so the address goes unacknowledged
	assign link_c.sda_oe_s = 1'b0;
	fsr_master i_fsr_master_c(.i_core_clk(clk), .i_rst(rst), .i_go(go_c), .i_fast(1'b1),
		.o_busy(c_busy), .o_done(), .o_nack(c_nack), .o_ok(c_ok), .o_flow(c_flow),
		.link(link_c.master));
	fsr_link_checker i_fsr_link_checker(.i_core_clk(clk), .i_rst(rst),
		.scl_oe_m(link_a.scl_oe_m), .sda_oe_m(link_a.sda_oe_m), .sda_oe_s(link_a.sda_oe_s),
		.scl(link_a.scl), .sda(link_a.sda));
	always #5 clk = ~clk;
	always @(posedge link_a.scl) cap <= {cap[62:0], link_a.sda};
	always @(negedge link_a.sda) if (link_a.scl) cap <= 64'h0;
	// Ceiling about a tenth above the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			error_cnt = error_cnt + 1;
			results();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 70000) begin
			@(negedge clk);
			n++;
		end
		chk(done, 1);
	endtask
	function automatic logic [54:0] frame(input logic [11:0] f);
		logic [7:0] hi;
		logic [7:0] cs;
		hi = {4'h0, f[11:8]};
		cs = 8'h00 - hi - f[7:0] - hi - f[7:0];
		return {fsr_pkg::FSR_ADDR, fsr_pkg::FSR_RD_BIT, 1'b0, cs, 1'b0, hi, 1'b0, f[7:0],
			1'b0, hi, 1'b0, f[7:0], 2'h2};
	endfunction
	task automatic bang(input logic b, output logic s);
		link_b.sda_oe_m = ~b;
		repeat (Q) @(negedge clk);
		link_b.scl_oe_m = 1'b0;
		repeat (Q) @(negedge clk);
		s = link_b.sda;
		repeat (Q) @(negedge clk);
		link_b.scl_oe_m = 1'b1;
		repeat (Q) @(negedge clk);
	endtask
	task automatic probe(input logic [7:0] adr, input logic [17:0] exp);
		logic s;
		logic [17:0] got;
		link_b.sda_oe_m = 1'b1;
		repeat (Q) @(negedge clk);
		link_b.scl_oe_m = 1'b1;
		for (int i = 0; i < 18; i++) begin
			bang((i < 8) ? adr[7 - i] : 1'b1, s);
			got = {got[16:0], s};
		end
		bang(1'b0, s);
		link_b.scl_oe_m = 1'b0;
		repeat (Q) @(negedge clk);
		link_b.sda_oe_m = 1'b0;
		repeat (Q) @(negedge clk);
		chk(got, exp);
		chk(s_busy_b, 0);
	endtask
	task automatic results();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		link_b.scl_oe_m = 1'b0;
		link_b.sda_oe_m = 1'b0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		go_c = 1'b1;
		@(negedge clk);
		go_c = 1'b0;
		foreach (rows[i]) begin
			flow = rows[i].f;
			fast = rows[i].fs;
			go = 1'b1;
			@(negedge clk);
			go = 1'b0;
			wait (link_a.sda_oe_s === 1'b1);
			@(negedge clk);
			flow = ~rows[i].f;
			go = 1'b1;
			@(negedge clk);
			go = 1'b0;
			wait_done();
			fr = frame(rows[i].f);
			chk(cap[54:0], fr);
			chk(got_flow, rows[i].f);
			chk({ok, nack}, {rows[i].okx, 1'b0});
		end
		chk({c_busy, c_nack, c_ok, c_flow}, {3'b010, 12'h000});
		flow = 12'h3a5;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		wait (link_a.sda_oe_s === 1'b1);
		@(negedge clk);
		rst = 1'b1;
		repeat (3) @(negedge clk);
		chk({m_busy, s_busy, done, ok, nack, got_flow, link_a.sda, link_a.scl}, 19'h3);
		rst = 1'b0;
		fr = frame(flow);
		probe(8'ha3, {8'ha3, 10'h3ff});
		probe(8'ha0, {8'ha0, 10'h3ff});
		probe(8'ha1, {8'ha1, 1'b0, fr[45:38], 1'b1});
		results();
	end
endmodule
